// File: hw/bcdc_map.vh
// Register map, field positions, reset values and timing counts of the BCD calendar clock.
// Assumes inclusion by bare name from the design files.
`ifndef BCDC_MAP_VH
`define BCDC_MAP_VH

// Time and date registers
`define BCDC_SECONDS_COUNT 8'h40
`define BCDC_MINUTES_COUNT 8'h41
`define BCDC_HOURS_COUNT 8'h42
`define BCDC_WEEKDAY_COUNT 8'h43
`define BCDC_DATE_COUNT 8'h44
`define BCDC_MONTH_COUNT 8'h45
`define BCDC_YEAR_COUNT 8'h46
// Alarm registers: first alarm 0x47..0x4a, second alarm 0x4b..0x4e
`define BCDC_ALARM_BASE 8'h47
`define BCDC_ALARM_LAST 8'h4e
// Alarm control and status
`define BCDC_ALARM_CTRL 8'h4f
`define BCDC_ALARM_STAT 8'h50

// Field positions
`define BCDC_HR_FMT_BIT 6
`define BCDC_HR_AFTERNOON_BIT 5
`define BCDC_MON_CENTURY_BIT 7
`define BCDC_AL_MASK_BIT 7
`define BCDC_AL_WEEKDAY_BIT 6

// Write masks of the counter registers
`define BCDC_SEC_WMASK 8'h7f
`define BCDC_MIN_WMASK 8'h7f
`define BCDC_HR_WMASK 8'h7f
`define BCDC_DAY_WMASK 8'h07
`define BCDC_DATE_WMASK 8'h3f
`define BCDC_MON_WMASK 8'h9f

// Reset values
`define BCDC_SEC_RST 8'h00
`define BCDC_MIN_RST 8'h00
`define BCDC_HR_RST 8'h00
`define BCDC_DAY_RST 8'h00
`define BCDC_DATE_RST 8'h01
`define BCDC_MON_RST 8'h01
`define BCDC_YEAR_RST 8'h00

// Reference periods in one second
`define BCDC_REF_PER_SEC 32768

`endif

// File: hw/bcdc_alarm.v
// One time/date alarm comparator with per-field masks.
// Assumes the counters and alarm bytes are stable in the cycle check is high.
`timescale 1ns/10ps
`default_nettype none
`include "bcdc_map.vh"

module bcdc_alarm (
   // Live counters
   input wire [7:0] sec,
   input wire [7:0] min,
   input wire [7:0] hr,
   input wire [7:0] day,
   input wire [7:0] date,
   // Alarm bytes: seconds, minutes, hours, day or date
   input wire [7:0] al_sec,
   input wire [7:0] al_min,
   input wire [7:0] al_hr,
   input wire [7:0] al_dd,
   // Once-per-second evaluation strobe and result
   input wire check,
   output wire hit
);

   wire mask_sec;
   wire mask_min;
   wire mask_hour;
   wire mask_daydate;
   wire weekday_select;
   wire sec_eq;
   wire min_eq;
   wire hr_eq;
   wire dd_eq;

   assign mask_sec = al_sec[`BCDC_AL_MASK_BIT];
   assign mask_min = al_min[`BCDC_AL_MASK_BIT];
   assign mask_hour = al_hr[`BCDC_AL_MASK_BIT];
   assign mask_daydate = al_dd[`BCDC_AL_MASK_BIT];
   assign weekday_select = al_dd[`BCDC_AL_WEEKDAY_BIT];

   assign sec_eq = mask_sec | (sec[6:0] == al_sec[6:0]);
   assign min_eq = mask_min | (min[6:0] == al_min[6:0]);
   assign hr_eq = mask_hour | (hr[6:0] == al_hr[6:0]);
   // Day-of-week or date of month as match target
   assign dd_eq = mask_daydate | (weekday_select ? (day[5:0] == al_dd[5:0]) : (date[5:0] == al_dd[5:0]));

   assign hit = check & sec_eq & min_eq & hr_eq & dd_eq;

endmodule
`default_nettype wire

// File: hw/bcdc_clock.v
// BCD calendar clock with two alarms, reached through a byte register port.
// Assumes a 10 MHz clk, a 32 kHz reference synchronous to clk, and reset only at first power-up.
//
// Operation
// - Seconds BCD 0..59, wrap, carry to minutes
// - Minutes BCD 0..59, wrap, carry to hours
// - Hours 1..12 or 0..23 by format
// - Hour bit 6 selects 12-hour format
// - Bit 5 afternoon, or upper tens bit
// - Month ends at correct date, leap Februaries
// - Year 99 to 0 toggles century bit
// - Weekday advances at midnight, consecutive values
// - Clock always runs, nothing stops it
// - Reset only at power-up; enables off
// - Minutes..year read via shadow; seconds read snapshots counters
// - Seconds write restarts sub-second chain
// - Write data transfers on write command
// - Bit 7 masks; all clear needs full match
// - Mask pattern sets the alarm repeat rate
// - Bit 6 picks date or weekday target
// - Alarms checked each second, flags set
// - Interrupt while enabled flag set, until cleared
// - Weekday counts BCD 1..7
// - Date counts 1..31 by month
// - Month counts 1..12, carries to year
// - Year counts 0..99 in BCD
`timescale 1ns/10ps
`default_nettype none
`include "bcdc_map.vh"

module bcdc_clock #(
   parameter REF_PER_SEC = `BCDC_REF_PER_SEC
) (
   // Clock and power-up reset
   input wire clk,
   input wire reset,
   // Low-frequency reference
   input wire ref_32k,
   // Register port
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // Alarm interrupt
   output reg alarm_irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // BCD helpers

   function [7:0] bcd_inc;
      input [7:0] v;
      begin
         if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
         end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
         end
      end
   endfunction

   function [7:0] month_last;
      input [7:0] mon;
      input [7:0] yr;
      reg [3:0] quad;
      begin
         quad = {2'b00, yr[4], 1'b0} + yr[3:0];
         case (mon[4:0])
            5'h02: month_last = (quad[1:0] == 2'b00) ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: month_last = 8'h30;
            default: month_last = 8'h31;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State

   reg [7:0] sec_r;
   reg [7:0] min_r;
   reg [7:0] hr_r;
   reg [7:0] day_r;
   reg [7:0] date_r;
   reg [7:0] mon_r;
   reg [7:0] year_r;
   reg [7:0] shadow_r [0:6];
   reg [7:0] alarm_r [0:7];
   reg first_alarm_irq_allow_r;
   reg second_alarm_irq_allow_r;
   reg first_alarm_hit_r;
   reg second_alarm_hit_r;
   reg ref_d_r;
   reg [15:0] div_r;
   reg tick_r;
   reg check_r;

   reg [7:0] sec_nxt;
   reg [7:0] min_nxt;
   reg [7:0] hr_nxt;
   reg [7:0] day_nxt;
   reg [7:0] date_nxt;
   reg [7:0] mon_nxt;
   reg [7:0] year_nxt;
   reg [15:0] div_nxt;
   reg tick_nxt;
   reg [7:0] rdata_nxt;
   reg [7:0] hr12_inc;
   reg [7:0] hr24_inc;
   reg [7:0] mon_inc;

   wire ref_rise;
   wire wr_sec;
   wire [1:0] hit;
   integer i;

   assign ref_rise = ref_32k & ~ref_d_r;
   assign wr_sec = reg_wr && (reg_addr == `BCDC_SECONDS_COUNT);

   ////////////////////////////////////////////////////////////////////////////////
   // One-second tick from the reference

   always @* begin
      div_nxt = div_r;
      tick_nxt = 1'b0;
      if (wr_sec) begin
         div_nxt = 16'h0000;
      end else if (ref_rise) begin
         if (div_r == REF_PER_SEC[15:0] - 16'h0001) begin
            div_nxt = 16'h0000;
            tick_nxt = 1'b1;
         end else begin
            div_nxt = div_r + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Calendar carry chain

   always @* begin
      sec_nxt = sec_r;
      min_nxt = min_r;
      hr_nxt = hr_r;
      day_nxt = day_r;
      date_nxt = date_r;
      mon_nxt = mon_r;
      year_nxt = year_r;
      hr12_inc = bcd_inc({3'b000, hr_r[4:0]});
      hr24_inc = bcd_inc({2'b00, hr_r[5:0]});
      mon_inc = bcd_inc({3'b000, mon_r[4:0]});
      // No enable gates this chain: the clock never stops
      if (tick_r) begin
         if (sec_r[6:0] == 7'h59) begin
            sec_nxt = 8'h00;
            if (min_r[6:0] == 7'h59) begin
               min_nxt = 8'h00;
               if (hr_r[`BCDC_HR_FMT_BIT]) begin
                  // 12-hour: 11 -> 12 flips afternoon, 12 -> 1
                  if (hr_r[4:0] == 5'h12) begin
                     hr_nxt = {hr_r[7:5], 5'h01};
                  end else if (hr_r[4:0] == 5'h11) begin
                     hr_nxt = {hr_r[7:6], ~hr_r[`BCDC_HR_AFTERNOON_BIT], 5'h12};
                  end else begin
                     hr_nxt = {hr_r[7:5], hr12_inc[4:0]};
                  end
               end else if (hr_r[5:0] == 6'h23) begin
                  hr_nxt = {hr_r[7:6], 6'h00};
               end else begin
                  hr_nxt = {hr_r[7:6], hr24_inc[5:0]};
               end
               // Midnight: 23 in 24-hour, 11 afternoon in 12-hour
               if ((!hr_r[`BCDC_HR_FMT_BIT] && hr_r[5:0] == 6'h23) ||
                   (hr_r[`BCDC_HR_FMT_BIT] && hr_r[`BCDC_HR_AFTERNOON_BIT] && hr_r[4:0] == 5'h11)) begin
                  day_nxt = (day_r[2:0] >= 3'h7) ? 8'h01 : {5'b00000, day_r[2:0] + 3'h1};
                  if ({2'b00, date_r[5:0]} >= month_last(mon_r, year_r)) begin
                     date_nxt = 8'h01;
                     if (mon_r[4:0] >= 5'h12) begin
                        mon_nxt = {mon_r[7], 7'h01};
                        if (year_r == 8'h99) begin
                           year_nxt = 8'h00;
                           mon_nxt = {~mon_r[`BCDC_MON_CENTURY_BIT], 7'h01};
                        end else begin
                           year_nxt = bcd_inc(year_r);
                        end
                     end else begin
                        mon_nxt = {mon_r[7], 2'b00, mon_inc[4:0]};
                     end
                  end else begin
                     date_nxt = bcd_inc(date_r) & `BCDC_DATE_WMASK;
                  end
               end
            end else begin
               min_nxt = bcd_inc(min_r) & `BCDC_MIN_WMASK;
            end
         end else begin
            sec_nxt = bcd_inc(sec_r) & `BCDC_SEC_WMASK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counters with direct write transfer

   always @(posedge clk) begin
      if (reset) begin
         sec_r <= `BCDC_SEC_RST;
         min_r <= `BCDC_MIN_RST;
         hr_r <= `BCDC_HR_RST;
         day_r <= `BCDC_DAY_RST;
         date_r <= `BCDC_DATE_RST;
         mon_r <= `BCDC_MON_RST;
         year_r <= `BCDC_YEAR_RST;
         // Track the pin in reset so no false edge follows release
         ref_d_r <= ref_32k;
         div_r <= 16'h0000;
         tick_r <= 1'b0;
         check_r <= 1'b0;
      end else begin
         ref_d_r <= ref_32k;
         div_r <= div_nxt;
         tick_r <= tick_nxt;
         check_r <= tick_r;
         // A write takes its field; other fields follow the chain
         sec_r <= (reg_wr && reg_addr == `BCDC_SECONDS_COUNT) ? (reg_wdata & `BCDC_SEC_WMASK) : sec_nxt;
         min_r <= (reg_wr && reg_addr == `BCDC_MINUTES_COUNT) ? (reg_wdata & `BCDC_MIN_WMASK) : min_nxt;
         hr_r <= (reg_wr && reg_addr == `BCDC_HOURS_COUNT) ? (reg_wdata & `BCDC_HR_WMASK) : hr_nxt;
         day_r <= (reg_wr && reg_addr == `BCDC_WEEKDAY_COUNT) ? (reg_wdata & `BCDC_DAY_WMASK) : day_nxt;
         date_r <= (reg_wr && reg_addr == `BCDC_DATE_COUNT) ? (reg_wdata & `BCDC_DATE_WMASK) : date_nxt;
         mon_r <= (reg_wr && reg_addr == `BCDC_MONTH_COUNT) ? (reg_wdata & `BCDC_MON_WMASK) : mon_nxt;
         year_r <= (reg_wr && reg_addr == `BCDC_YEAR_COUNT) ? reg_wdata : year_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Alarm settings, enables and flags

   always @(posedge clk) begin
      if (reset) begin
         for (i = 0; i < 8; i = i + 1) begin
            alarm_r[i] <= 8'h00;
         end
         first_alarm_irq_allow_r <= 1'b0;
         second_alarm_irq_allow_r <= 1'b0;
         first_alarm_hit_r <= 1'b0;
         second_alarm_hit_r <= 1'b0;
      end else begin
         if (reg_wr && reg_addr >= `BCDC_ALARM_BASE && reg_addr <= `BCDC_ALARM_LAST) begin
            alarm_r[reg_addr[2:0] - 3'h7] <= reg_wdata;
         end
         if (reg_wr && reg_addr == `BCDC_ALARM_CTRL) begin
            first_alarm_irq_allow_r <= reg_wdata[0];
            second_alarm_irq_allow_r <= reg_wdata[1];
         end
         // Writing one clears a flag; a hit in the same cycle wins
         first_alarm_hit_r <= (first_alarm_hit_r &
            ~(reg_wr && reg_addr == `BCDC_ALARM_STAT && reg_wdata[0])) | hit[0];
         second_alarm_hit_r <= (second_alarm_hit_r &
            ~(reg_wr && reg_addr == `BCDC_ALARM_STAT && reg_wdata[1])) | hit[1];
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gen_alarm
         bcdc_alarm u_alarm (
            .sec(sec_r),
            .min(min_r),
            .hr(hr_r),
            .day(day_r),
            .date(date_r),
            .al_sec(alarm_r[4 * g]),
            .al_min(alarm_r[4 * g + 1]),
            .al_hr(alarm_r[4 * g + 2]),
            .al_dd(alarm_r[4 * g + 3]),
            .check(check_r),
            .hit(hit[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Shadow read buffers and read data

   always @* begin
      rdata_nxt = reg_rdata;
      if (reg_rd) begin
         if (reg_addr == `BCDC_SECONDS_COUNT) begin
            rdata_nxt = sec_r;
         end else if (reg_addr >= `BCDC_MINUTES_COUNT && reg_addr <= `BCDC_YEAR_COUNT) begin
            rdata_nxt = shadow_r[reg_addr[2:0]];
         end else if (reg_addr >= `BCDC_ALARM_BASE && reg_addr <= `BCDC_ALARM_LAST) begin
            rdata_nxt = alarm_r[reg_addr[2:0] - 3'h7];
         end else if (reg_addr == `BCDC_ALARM_CTRL) begin
            rdata_nxt = {6'h00, second_alarm_irq_allow_r, first_alarm_irq_allow_r};
         end else if (reg_addr == `BCDC_ALARM_STAT) begin
            rdata_nxt = {6'h00, second_alarm_hit_r, first_alarm_hit_r};
         end else begin
            rdata_nxt = 8'h00;
         end
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         // Match the counters so a read before any snapshot shows defaults
         shadow_r[0] <= `BCDC_SEC_RST;
         shadow_r[1] <= `BCDC_MIN_RST;
         shadow_r[2] <= `BCDC_HR_RST;
         shadow_r[3] <= `BCDC_DAY_RST;
         shadow_r[4] <= `BCDC_DATE_RST;
         shadow_r[5] <= `BCDC_MON_RST;
         shadow_r[6] <= `BCDC_YEAR_RST;
         reg_rdata <= 8'h00;
         alarm_irq <= 1'b0;
      end else begin
         reg_rdata <= rdata_nxt;
         // Snapshot so a multi-byte read sees one consistent instant
         if (reg_rd && reg_addr == `BCDC_SECONDS_COUNT) begin
            shadow_r[0] <= sec_r;
            shadow_r[1] <= min_r;
            shadow_r[2] <= hr_r;
            shadow_r[3] <= day_r;
            shadow_r[4] <= date_r;
            shadow_r[5] <= mon_r;
            shadow_r[6] <= year_r;
         end
         alarm_irq <= (first_alarm_hit_r & first_alarm_irq_allow_r) |
                      (second_alarm_hit_r & second_alarm_irq_allow_r);
      end
   end

endmodule
`default_nettype wire

// File: bench/bcdc_host.sv
// Host model driving the register port of the calendar clock.
// Assumes its tasks are entered just after a falling clk edge.
`timescale 1ns/10ps
`default_nettype none
module bcdc_host (
   // Clock
   input wire logic clk,
   // Register port
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // The strobe stays up when another access follows
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_rd = 1'b0;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      reg_addr = a;
      reg_wdata = ~reg_wdata;
      @(negedge clk);
      q = reg_rdata;
   endtask
   task automatic idle(input int n);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = ~reg_wdata;
      repeat (n) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// File: bench/bcdc_clock_asserts.sv
// Checker of the register port and alarm output of the calendar clock.
// Assumes binding to bcdc_clock, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module bcdc_clock_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Alarm interrupt
   input wire logic alarm_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic clr_d;
   wire clr = reg_wr && (reg_addr == 8'h4f || reg_addr == 8'h50);
   always @(posedge clk) begin
      if (reset) begin
         clr_d <= 1'b0;
      end else begin
         clr_d <= clr;
      end
   end
   sequence s_sec_wr;
      reg_wr && reg_addr == 8'h40;
   endsequence
   sequence s_sec_rd;
      reg_rd && reg_addr == 8'h40;
   endsequence
   property p_sec_back;
      s_sec_wr ##1 s_sec_rd |=> reg_rdata == (8'h7f & $past(reg_wdata, 2));
   endproperty
   a_sec_back: assert property (p_sec_back) else $error("seconds write not kept");
   property p_rst_out;
      disable iff (1'b0) reset |=> reg_rdata == 8'h00 && !alarm_irq;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs not cleared");
   property p_sec_bcd;
      s_sec_rd |=> reg_rdata[7:4] <= 4'h5 && reg_rdata[3:0] <= 4'h9;
   endproperty
   a_sec_bcd: assert property (p_sec_bcd) else $error("seconds out of range");
   property p_hr_rng;
      reg_rd && reg_addr == 8'h42 |=> !reg_rdata[7] && reg_rdata[3:0] <= 4'h9 && (reg_rdata[6] ?
         (reg_rdata[4] ? reg_rdata[3:0] <= 4'h2 : reg_rdata[3:0] != 4'h0) : reg_rdata[5:0] <= 6'h23);
   endproperty
   a_hr_rng: assert property (p_hr_rng) else $error("hours out of range");
   property p_day_rng;
      reg_rd && reg_addr == 8'h43 |=> reg_rdata <= 8'h07;
   endproperty
   a_day_rng: assert property (p_day_rng) else $error("weekday out of range");
   property p_date_rng;
      reg_rd && reg_addr == 8'h44 |=> reg_rdata <= 8'h31 && reg_rdata[3:0] <= 4'h9 && reg_rdata != 8'h00;
   endproperty
   a_date_rng: assert property (p_date_rng) else $error("date out of range");
   property p_mon_rng;
      reg_rd && reg_addr == 8'h45 |=> reg_rdata[6:5] == 2'b00 &&
         (reg_rdata[4] ? reg_rdata[3:0] <= 4'h2 : reg_rdata[3:0] != 4'h0 && reg_rdata[3:0] <= 4'h9);
   endproperty
   a_mon_rng: assert property (p_mon_rng) else $error("month out of range");
   property p_unmapped;
      reg_rd && (reg_addr < 8'h40 || reg_addr > 8'h50) |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_rd_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_irq_hold;
      alarm_irq && !clr && !clr_d |=> alarm_irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
   property p_irq_off;
      reg_wr && reg_addr == 8'h4f && reg_wdata[1:0] == 2'b00 |-> ##2 !alarm_irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
endmodule
bind bcdc_clock bcdc_clock_chk i_bcdc_clock_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .alarm_irq(alarm_irq));
`default_nettype wire

// File: bench/bcdc_clock_tb.sv
// Self-checking bench of the calendar clock.
// Assumes bcdc_host on the register port and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module bcdc_clock_tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ref_32k = 1'b0;
   wire [7:0] reg_addr;
   wire reg_wr;
   wire reg_rd;
   wire [7:0] reg_wdata;
   wire [7:0] reg_rdata;
   wire alarm_irq;
   int error_cnt = 0;
   int samples_checked = 0;
   // {hr,date,mon,yr} then expected {hr,day,date,mon,yr}
   logic [71:0] cases [0:8] = '{72'h23_28_02_24_00_04_29_02_24, 72'h23_29_02_24_00_04_01_03_24,
      72'h23_28_02_23_00_04_01_03_23, 72'h23_30_04_23_00_04_01_05_23, 72'h23_31_12_23_00_04_01_01_24,
      72'h71_10_04_23_52_04_11_04_23, 72'h51_10_04_23_72_03_10_04_23, 72'h72_10_04_23_61_03_10_04_23,
      72'h09_10_04_23_10_03_10_04_23};
   // {fires, alarm one bytes}
   logic [32:0] als [0:4] = '{33'h1_02_10_05_43, 33'h0_02_10_05_03, 33'h1_02_10_05_07,
      33'h1_02_10_86_81, 33'h1_02_10_05_81};
   always #50 clk = ~clk;
   // Four rising reference edges make one second
   always #200 ref_32k = ~ref_32k;
   bcdc_clock #(.REF_PER_SEC(4)) i_bcdc_clock (.clk(clk), .reset(reset), .ref_32k(ref_32k), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .alarm_irq(alarm_irq));
   bcdc_host i_bcdc_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      if (error_cnt == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      i_bcdc_host.rd(a, q);
      cmp(q, exp);
   endtask
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      i_bcdc_host.wr(a, d);
   endtask
   // Seconds first, the rest well inside half a second
   task automatic set_time(input logic [55:0] t);
      for (int i = 0; i < 7; i++) w(8'h40 + 8'(i), t[55-8*i -: 8]);
   endtask
   task automatic chk_all(input logic [55:0] e);
      for (int i = 0; i < 7; i++) chk(8'h40 + 8'(i), e[55-8*i -: 8]);
   endtask
   task automatic wait_irq(input int n, input logic exp);
      i_bcdc_host.idle(1);
      for (int k = 0; k < n && alarm_irq !== 1'b1; k++) @(negedge clk);
      cmp({7'h00, alarm_irq}, {7'h00, exp});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (20) @(negedge clk);
      reset = 1'b0;
      for (int a = 8'h3f; a <= 8'h51; a++) chk(8'(a), (a == 8'h44 || a == 8'h45) ? 8'h01 : 8'h00);
      w(8'h51, 8'hff);
      chk(8'h51, 8'h00);
      set_time(56'h58_59_23_07_31_12_99);
      i_bcdc_host.idle(32);
      chk(8'h45, 8'h01);
      chk_all(56'h00_00_00_01_01_81_00);
      for (int i = 0; i < 9; i++) begin
         set_time({16'h5959, cases[i][71:64], 8'h03, cases[i][63:40]});
         i_bcdc_host.idle(16);
         chk_all({16'h0000, cases[i][39:0]});
      end
      repeat (4) begin
         w(8'h40, 8'h30);
         chk(8'h40, 8'h30);
         i_bcdc_host.idle(9);
         chk(8'h40, 8'h30);
      end
      for (int a = 8'h47; a <= 8'h4a; a++) w(8'(a), 8'h80);
      w(8'h4f, 8'h01);
      wait_irq(40, 1'b1);
      chk(8'h50, 8'h01);
      i_bcdc_host.idle(4);
      cmp({7'h00, alarm_irq}, 8'h01);
      w(8'h50, 8'h01);
      i_bcdc_host.idle(3);
      cmp({7'h00, alarm_irq}, 8'h00);
      w(8'h4f, 8'h00);
      w(8'h50, 8'h03);
      wait_irq(40, 1'b0);
      chk(8'h50, 8'h01);
      for (int a = 8'h4b; a <= 8'h4e; a++) w(8'(a), (a == 8'h4b) ? 8'h03 : 8'h80);
      w(8'h50, 8'h03);
      w(8'h4f, 8'h02);
      w(8'h40, 8'h00);
      wait_irq(90, 1'b1);
      chk(8'h40, 8'h03);
      set_time(56'h00_10_05_03_07_04_23);
      w(8'h4f, 8'h01);
      for (int i = 0; i < 5; i++) begin
         for (int a = 0; a < 4; a++) w(8'h47 + 8'(a), als[i][31-8*a -: 8]);
         w(8'h40, 8'h00);
         w(8'h50, 8'h03);
         i_bcdc_host.idle(2);
         wait_irq(60, als[i][32]);
         if (als[i][32])
            chk(8'h40, 8'h02);
      end
      // Second reset in mid-run, with an interrupt pending
      i_bcdc_host.idle(1);
      reset = 1'b1;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      cmp({7'h00, alarm_irq}, 8'h00);
      chk(8'h44, 8'h01);
      chk(8'h4f, 8'h00);
      chk(8'h50, 8'h00);
      chk_all(56'h00_00_00_00_01_01_00);
      finish_test();
   end
endmodule
`default_nettype wire
